// ==== core/pthl_map.svh ====
// Register map, field layout, reset values and decode constants for the period timer.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef PTHL_MAP_SVH
`define PTHL_MAP_SVH
`define PTHL_OFS_COUNT   12'h000
`define PTHL_OFS_PERIOD  12'h004
`define PTHL_OFS_CTRL    12'h008
`define PTHL_OFS_LIMIT   12'h00C
`define PTHL_OFS_FLAG    12'h010
`define PTHL_PERIOD_RST  8'hFF
`define PTHL_COUNT_RST   8'h00
`define PTHL_CTRL_RST    8'h00
`define PTHL_LIMIT_RST   5'h00
`define PTHL_CTRL_RUN    7
`define PTHL_CTRL_PRE_HI 6
`define PTHL_CTRL_PRE_LO 4
`define PTHL_CTRL_PST_HI 3
`define PTHL_CTRL_PST_LO 0
`define PTHL_LIM_ASYNC   5
`define PTHL_LIM_MODE_HI 4
`define PTHL_LIM_MODE_LO 0
`define PTHL_PRE_ONE     7'h01
`endif

// ==== core/pthl_pkg.sv ====
// Types shared by the period timer design.
// Constants live in pthl_map.svh.
package pthl_pkg;
	typedef enum logic [1:0] {
		PTHL_FREE = 2'h0,
		PTHL_ONESHOT = 2'h1,
		PTHL_MONO = 2'h2,
		PTHL_RSVD = 2'h3
	} pthl_major_t;

	typedef struct packed {
		logic [7:0] count;
		logic       tick;
		logic       match;
		logic       period_pulse;
	} pthl_pwm_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pthl_apb_req_t;
endpackage : pthl_pkg

// ==== core/pthl_timer.sv ====
// Period timer with hardware limit control, APB register slave.
// Assumes the external reset signal and timer clock arrive from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "pthl_map.svh"
module pthl_timer
	import pthl_pkg::*;
(
	// Clock, reset, enable
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          clk_en,
	// APB slave
	input  wire pthl_apb_req_t apb_req,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// External signals
	input  wire logic          timer_clk_in,
	input  wire logic          external_reset_signal,
	input  wire logic          debug_freeze,
	// Peripheral outputs
	output pthl_pwm_t          pwm_out,
	output logic               period_pulse_out
);
	logic [1:0] tsync_q, tsync_d, esync_q, esync_d;
	logic       tprev_q, tprev_d, eprev_q, eprev_d;
	logic [7:0] cnt_q, cnt_d, per_q, per_d, ctl_q, ctl_d;
	logic [5:0] lim_q, lim_d;
	logic [6:0] pre_q, pre_d;
	logic [3:0] pst_q, pst_d;
	logic       flag_q, flag_d, pulse_q, pulse_d, armed_q, armed_d;
	logic       runprev_q, runprev_d, match_q, match_d;

	// Ratio 1:2^n for the prescaler select field.
	function automatic logic [6:0] pre_limit(input logic [2:0] sel);
		pre_limit = 7'((8'h01 << sel) - 8'h01);
	endfunction : pre_limit

	logic       wr, rd, ext_raw, tick_src, tick, run;
	logic       e_rise, e_fall, e_lvl, e_clr, e_start, sreset;
	logic [2:0] sub;
	pthl_major_t major;

	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd = apb_req.psel && !apb_req.pwrite;
	assign pready = 1'b1;
	assign run = ctl_q[`PTHL_CTRL_RUN];
	assign major = pthl_major_t'(lim_q[`PTHL_LIM_MODE_HI:`PTHL_LIM_MODE_HI-1]);
	assign sub = lim_q[2:0];
	// The second synchroniser stage is the only one read by logic.
	assign ext_raw = esync_q[1] && !debug_freeze;
	assign e_rise = ext_raw && !eprev_q;
	assign e_fall = !ext_raw && eprev_q;
	// The async select bit is stored and read back, but both settings take the tick from
	// the second synchroniser stage: with a single clock a raw pin edge cannot be used
	// safely, so the trade is two cycles of extra tick latency for metastability safety.
	assign tick_src = lim_q[`PTHL_LIM_ASYNC] ? tsync_q[1] : tsync_q[1];
	// The exported tick is held off while stopped so that consumers see no phantom ticks.
	assign tick = clk_en && run && tick_src && !tprev_q
		&& (pre_q == pre_limit(ctl_q[6:4]));

	always_comb begin
		e_lvl = 1'b1;
		e_clr = 1'b0;
		e_start = 1'b0;
		unique case (major)
			PTHL_FREE: begin
				unique case (sub)
					3'h1: e_lvl = ext_raw;
					3'h2: e_lvl = !ext_raw;
					3'h3: e_clr = e_rise || e_fall;
					3'h4: e_clr = e_rise;
					3'h5: e_clr = e_fall;
					3'h6: e_clr = !ext_raw;
					3'h7: e_clr = ext_raw;
					default: e_lvl = 1'b1;
				endcase
			end
			PTHL_ONESHOT, PTHL_MONO: begin
				unique case (sub)
					3'h0: e_start = (major == PTHL_ONESHOT);
					3'h1, 3'h4: e_start = e_rise;
					3'h2, 3'h5: e_start = e_fall;
					3'h3: e_start = e_rise || e_fall;
					3'h6: e_start = (major == PTHL_MONO) ? ext_raw : e_rise;
					default: e_start = (major == PTHL_MONO) ? !ext_raw : e_fall;
				endcase
				if (major == PTHL_ONESHOT) begin
					e_clr = (sub == 3'h4 && e_rise) || (sub == 3'h5 && e_fall)
						|| (sub == 3'h6 && !ext_raw) || (sub == 3'h7 && ext_raw);
				end else if (sub >= 3'h6) begin
					e_clr = (sub == 3'h6) ? !ext_raw : ext_raw;
				end
				if (major == PTHL_MONO && (sub == 3'h0 || sub == 3'h4 || sub == 3'h5)) begin
					e_start = 1'b0;
				end
			end
			PTHL_RSVD: e_lvl = 1'b0;
		endcase
	end

	assign sreset = wr && (apb_req.paddr == `PTHL_OFS_COUNT || apb_req.paddr == `PTHL_OFS_CTRL);

	always_comb begin
		tsync_d = {tsync_q[0], timer_clk_in};
		esync_d = {esync_q[0], external_reset_signal};
		tprev_d = tick_src;
		eprev_d = ext_raw;
		cnt_d = cnt_q;
		per_d = per_q;
		ctl_d = ctl_q;
		lim_d = lim_q;
		pre_d = pre_q;
		pst_d = pst_q;
		pulse_d = 1'b0;
		flag_d = flag_q;
		armed_d = armed_q;
		runprev_d = run;
		match_d = (cnt_q == per_q);
		if (run && !runprev_q) begin
			armed_d = 1'b0;
		end
		if (run && tick_src && !tprev_q && major != PTHL_RSVD && e_lvl) begin
			pre_d = (pre_q == pre_limit(ctl_q[6:4])) ? 7'h00 : 7'(pre_q + 7'h01);
		end
		if (e_start && run) begin
			armed_d = 1'b1;
		end
		if (run && tick && e_lvl && (major == PTHL_FREE || armed_q) && major != PTHL_RSVD) begin
			if (cnt_q == per_q) begin
				cnt_d = `PTHL_COUNT_RST;
				if (pst_q == ctl_q[3:0]) begin
					pst_d = 4'h0;
					pulse_d = 1'b1;
				end else begin
					pst_d = 4'(pst_q + 4'h1);
				end
				if (major == PTHL_ONESHOT) begin
					ctl_d[`PTHL_CTRL_RUN] = 1'b0;
				end
				if (major != PTHL_FREE) begin
					armed_d = 1'b0;
				end
			end else begin
				cnt_d = 8'(cnt_q + 8'h01);
			end
		end
		if (run && e_clr) begin
			cnt_d = `PTHL_COUNT_RST;
			pre_d = 7'h00;
			pst_d = 4'h0;
		end
		if (wr) begin
			unique case (apb_req.paddr)
				`PTHL_OFS_COUNT: begin
					cnt_d = apb_req.pwdata[7:0];
					pre_d = 7'h00;
					pst_d = 4'h0;
				end
				`PTHL_OFS_PERIOD: per_d = apb_req.pwdata[7:0];
				`PTHL_OFS_CTRL: begin
					ctl_d = apb_req.pwdata[7:0];
					pre_d = 7'h00;
					pst_d = 4'h0;
				end
				`PTHL_OFS_LIMIT: lim_d = apb_req.pwdata[5:0];
				`PTHL_OFS_FLAG: flag_d = flag_q && !apb_req.pwdata[0];
				default: flag_d = flag_q;
			endcase
		end
		if (pulse_d) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tsync_q <= 2'h0;
			esync_q <= 2'h0;
			tprev_q <= 1'b0;
			eprev_q <= 1'b0;
			cnt_q <= `PTHL_COUNT_RST;
			per_q <= `PTHL_PERIOD_RST;
			ctl_q <= `PTHL_CTRL_RST;
			lim_q <= {1'b0, `PTHL_LIMIT_RST};
			pre_q <= 7'h00;
			pst_q <= 4'h0;
			pulse_q <= 1'b0;
			flag_q <= 1'b0;
			armed_q <= 1'b0;
			runprev_q <= 1'b0;
			match_q <= 1'b0;
		end else if (clk_en) begin
			tsync_q <= tsync_d;
			esync_q <= esync_d;
			tprev_q <= tprev_d;
			eprev_q <= eprev_d;
			cnt_q <= cnt_d;
			per_q <= per_d;
			ctl_q <= ctl_d;
			lim_q <= lim_d;
			pre_q <= pre_d;
			pst_q <= pst_d;
			pulse_q <= pulse_d;
			flag_q <= flag_d;
			armed_q <= armed_d;
			runprev_q <= runprev_d;
			match_q <= match_d;
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		if (rd) begin
			unique case (apb_req.paddr)
				`PTHL_OFS_COUNT: prdata = {24'h000000, cnt_q};
				`PTHL_OFS_PERIOD: prdata = {24'h000000, per_q};
				`PTHL_OFS_CTRL: prdata = {24'h000000, ctl_q};
				`PTHL_OFS_LIMIT: prdata = {26'h0000000, lim_q};
				`PTHL_OFS_FLAG: prdata = {31'h00000000, flag_q};
				default: pslverr = apb_req.penable;
			endcase
		end else if (apb_req.psel && apb_req.penable) begin
			pslverr = !(apb_req.paddr inside {`PTHL_OFS_COUNT, `PTHL_OFS_PERIOD,
				`PTHL_OFS_CTRL, `PTHL_OFS_LIMIT, `PTHL_OFS_FLAG});
		end
	end

	assign period_pulse_out = pulse_q;
	assign pwm_out = '{count: cnt_q, tick: tick, match: match_q, period_pulse: pulse_q};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	reset_period_a: assert property ($rose(rst_n) |-> per_q == `PTHL_PERIOD_RST)
		else $error("period not FFh after reset");
	count_step_a: assert property (run && tick && e_lvl && major == PTHL_FREE && !e_clr && !wr
		&& cnt_q != per_q |=> cnt_q == $past(cnt_q) + 8'h01)
		else $error("count did not step");
	match_wrap_a: assert property (run && tick && e_lvl && major == PTHL_FREE && !wr
		&& cnt_q == per_q |=> cnt_q == 8'h00)
		else $error("count not cleared after match");
	pulse_width_a: assert property (clk_en && pulse_q |=> !pulse_q)
		else $error("period pulse longer than one cycle");
	oneshot_stop_a: assert property (run && tick && armed_q && major == PTHL_ONESHOT && !wr
		&& cnt_q == per_q |=> !run)
		else $error("one-shot did not stop");
	ctrl_keep_a: assert property (clk_en && wr && apb_req.paddr == `PTHL_OFS_CTRL && !tick
		&& !e_clr |=> cnt_q == $past(cnt_q))
		else $error("control write changed count");
	scaler_clear_a: assert property (clk_en && wr && apb_req.paddr == `PTHL_OFS_COUNT
		|=> pre_q == 7'h00 && pst_q == 4'h0)
		else $error("scalers not cleared");
	rsvd_idle_a: assert property (clk_en && major == PTHL_RSVD && !wr |=> cnt_q == $past(cnt_q))
		else $error("reserved mode counted");
	flag_set_a: assert property (clk_en && pulse_q |-> flag_q)
		else $error("flag missing on pulse");
	freeze_a: assert property (debug_freeze |-> !ext_raw)
		else $error("external input not frozen");

	// A counting tick that lands on the period value, with nothing overriding it.
	sequence count_match_s;
		run && tick && e_lvl && (major == PTHL_FREE || armed_q) && major != PTHL_RSVD
			&& cnt_q == per_q && !wr && !e_clr;
	endsequence
	// The postscaler has reached its select value.
	sequence post_full_s;
		pst_q == ctl_q[`PTHL_CTRL_PST_HI:`PTHL_CTRL_PST_LO];
	endsequence
	// The postscaler is still below its select value.
	sequence post_short_s;
		pst_q != ctl_q[`PTHL_CTRL_PST_HI:`PTHL_CTRL_PST_LO];
	endsequence

	post_pulse_a: assert property (count_match_s ##0 post_full_s |=> pulse_q && pst_q == 4'h0)
		else $error("postscaler match gave no pulse");
	post_step_a: assert property (count_match_s ##0 post_short_s
		|=> pst_q == 4'($past(pst_q) + 4'h1) && !pulse_q)
		else $error("postscaler did not step on match");
	match_out_a: assert property (clk_en |=> match_q == $past(cnt_q == per_q))
		else $error("match output wrong");
	ext_clear_a: assert property (clk_en && run && e_clr && !wr
		|=> cnt_q == `PTHL_COUNT_RST && pre_q == 7'h00 && pst_q == 4'h0)
		else $error("external reset did not clear");
	per_write_a: assert property (clk_en && wr && apb_req.paddr == `PTHL_OFS_PERIOD
		|=> per_q == $past(apb_req.pwdata[7:0]))
		else $error("period write lost");
	gate_hold_a: assert property (clk_en && run && !e_lvl && !e_clr && !wr
		|=> cnt_q == $past(cnt_q))
		else $error("count moved with gate closed");
	mono_keep_a: assert property (run && tick && armed_q && major == PTHL_MONO && !wr
		&& cnt_q == per_q |=> run && !armed_q && cnt_q == `PTHL_COUNT_RST)
		else $error("monostable did not stop with run kept");
	oneshot_zero_a: assert property (run && tick && armed_q && major == PTHL_ONESHOT && !wr
		&& cnt_q == per_q |=> cnt_q == `PTHL_COUNT_RST)
		else $error("one-shot count not left at zero");
	flag_clear_a: assert property (clk_en && wr && apb_req.paddr == `PTHL_OFS_FLAG
		&& apb_req.pwdata[0] |=> !flag_q || pulse_q)
		else $error("flag clear ignored");
endmodule : pthl_timer
`default_nettype wire

// ==== sim/pthl_sink.sv ====
// Consumer-side model of the timer outputs: measures tick and period pulse spacing.
// Assumes it shares the timer's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module pthl_sink
	import pthl_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Timer outputs
	input  wire pthl_pwm_t  pwm,
	input  wire logic       pulse,
	// Measurements
	output var logic [15:0] tick_gap_q,
	output var logic [15:0] pulse_gap_q
);
	logic [15:0] cyc_q;
	logic [15:0] cyc_d;
	logic [15:0] tcnt_q;
	logic [15:0] tcnt_d;
	logic [15:0] tick_gap_d;
	logic [15:0] pulse_gap_d;

	// A tick never coincides with a pulse, which lags its tick by a cycle.
	always_comb begin
		cyc_d = pwm.tick ? 16'h1 : cyc_q + 16'h1;
		tick_gap_d = pwm.tick ? cyc_q : tick_gap_q;
		tcnt_d = pulse ? 16'h0 : tcnt_q + {15'h0, pwm.tick};
		pulse_gap_d = pulse ? tcnt_q : pulse_gap_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q <= '0;
			tcnt_q <= '0;
			tick_gap_q <= '0;
			pulse_gap_q <= '0;
		end else begin
			cyc_q <= cyc_d;
			tcnt_q <= tcnt_d;
			tick_gap_q <= tick_gap_d;
			pulse_gap_q <= pulse_gap_d;
		end
	end
endmodule : pthl_sink
`default_nettype wire

// ==== sim/period_timer_hw_limit_tb.sv ====
// Self-checking bench for the period timer, driven over APB.
// Assumes a raw timer clock with a rising edge every four system clocks.
`timescale 1ns/100ps
`default_nettype none
`include "pthl_map.svh"
module period_timer_hw_limit_tb
	import pthl_pkg::*;
;
	logic           clk = 0;
	logic           rst_n = 0;
	logic           ers = 0;
	logic           dbg = 0;
	logic [1:0]     tdiv = 0;
	pthl_apb_req_t  req = '0;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	logic           ppo;
	pthl_pwm_t      pwm;
	logic [15:0]    tick_gap;
	logic [15:0]    pulse_gap;
	int             fail_count = 0;
	int             n_tests = 0;
	logic [31:0]    r;
	logic [31:0]    c;
	logic [7:0]     p;
	logic [3:0]     s;
	logic           e;

	always #12.5 clk = ~clk;
	always @(posedge clk) tdiv <= tdiv + 2'h1;

	pthl_timer dut(.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_clk_in(tdiv[1]),
		.external_reset_signal(ers), .debug_freeze(dbg), .pwm_out(pwm), .period_pulse_out(ppo));
	pthl_sink sink(.clk(clk), .rst_n(rst_n), .pwm(pwm), .pulse(ppo),
		.tick_gap_q(tick_gap), .pulse_gap_q(pulse_gap));

	function automatic logic [31:0] ctl(input logic run, input logic [2:0] pre, input logic [3:0] ps);
		return {24'h0, run, pre, ps};
	endfunction : ctl

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		r = prdata;
		e = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, r, exp);
	endtask : rd_chk

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end

	initial begin
		void'($urandom(32'h84d3));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk("count", `PTHL_OFS_COUNT, 32'h0);
		rd_chk("period", `PTHL_OFS_PERIOD, 32'hFF);
		rd_chk("unmapped", 12'h020, 32'h0);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("pready", {31'h0, pready}, 32'h1);
		apb(1'b1, 12'h020, 32'h5A);
		check("unmapped wr err", {31'h0, e}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			c = $urandom;
			apb(1'b1, `PTHL_OFS_COUNT, c);
			apb(1'b1, `PTHL_OFS_PERIOD, ~c);
			rd_chk("count rw", `PTHL_OFS_COUNT, {24'h0, c[7:0]});
			rd_chk("period rw", `PTHL_OFS_PERIOD, {24'h0, ~c[7:0]});
		end
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			p = 8'h2 + 8'($urandom % 8);
			s = 4'($urandom % 4);
			apb(1'b1, `PTHL_OFS_PERIOD, {24'h0, p});
			apb(1'b1, `PTHL_OFS_COUNT, 32'h0);
			apb(1'b1, `PTHL_OFS_CTRL, ctl(1'b1, 3'h0, s));
			repeat ((p + 1) * (s + 1) * 12) @(posedge clk);
			check("pulse gap", {16'h0, pulse_gap}, (p + 1) * (s + 1));
			apb(1'b1, `PTHL_OFS_CTRL, 32'h0);
			rd_chk("flag", `PTHL_OFS_FLAG, 32'h1);
			apb(1'b1, `PTHL_OFS_FLAG, 32'h1);
			rd_chk("flag clr", `PTHL_OFS_FLAG, 32'h0);
		end
		apb(1'b0, `PTHL_OFS_COUNT, 32'h0);
		c = r;
		apb(1'b1, `PTHL_OFS_CTRL, ctl(1'b0, 3'h2, 4'h5));
		rd_chk("count kept", `PTHL_OFS_COUNT, c);
		$display("test free run done");
		apb(1'b1, `PTHL_OFS_PERIOD, 32'hFF);
		for (int k = 0; k < 8; k += 3 + (k == 3)) begin
			apb(1'b1, `PTHL_OFS_CTRL, ctl(1'b1, 3'(k), 4'h0));
			repeat ((4 << k) * 3) @(posedge clk);
			check("tick gap", {16'h0, tick_gap}, 32'(4 << k));
		end
		$display("test prescale done");
		for (int j = 0; j < 2; j++) begin
			apb(1'b1, `PTHL_OFS_CTRL, 32'h0);
			apb(1'b1, `PTHL_OFS_LIMIT, j ? 32'h11 : 32'h09);
			apb(1'b1, `PTHL_OFS_PERIOD, 32'h5);
			apb(1'b1, `PTHL_OFS_COUNT, 32'h0);
			apb(1'b1, `PTHL_OFS_CTRL, ctl(1'b1, 3'h0, 4'h0));
			ers <= 1'b1;
			repeat (80) @(posedge clk);
			ers <= 1'b0;
			rd_chk("run after match", `PTHL_OFS_CTRL, j ? 32'h80 : 32'h0);
			rd_chk("stopped count", `PTHL_OFS_COUNT, 32'h0);
		end
		apb(1'b1, `PTHL_OFS_LIMIT, 32'h18);
		apb(1'b1, `PTHL_OFS_COUNT, 32'h10);
		apb(1'b1, `PTHL_OFS_CTRL, 32'h80);
		repeat (40) @(posedge clk);
		rd_chk("reserved mode", `PTHL_OFS_COUNT, 32'h10);
		$display("test modes done");
		apb(1'b1, `PTHL_OFS_PERIOD, 32'hFF);
		apb(1'b1, `PTHL_OFS_LIMIT, 32'h01);
		apb(1'b1, `PTHL_OFS_COUNT, 32'h0);
		repeat (40) @(posedge clk);
		apb(1'b0, `PTHL_OFS_COUNT, 32'h0);
		c = r;
		repeat (40) @(posedge clk);
		rd_chk("gate closed", `PTHL_OFS_COUNT, c);
		ers <= 1'b1;
		repeat (40) @(posedge clk);
		apb(1'b0, `PTHL_OFS_COUNT, 32'h0);
		check("gate open", {31'h0, r != c}, 32'h1);
		apb(1'b1, `PTHL_OFS_LIMIT, 32'h07);
		apb(1'b1, `PTHL_OFS_COUNT, 32'h40);
		repeat (20) @(posedge clk);
		rd_chk("level reset", `PTHL_OFS_COUNT, 32'h0);
		dbg <= 1'b1;
		repeat (60) @(posedge clk);
		apb(1'b0, `PTHL_OFS_COUNT, 32'h0);
		check("freeze", {31'h0, r != 32'h0}, 32'h1);
		$display("test external done");
		complete_run();
	end
endmodule : period_timer_hw_limit_tb
`default_nettype wire
